// *** include/tdac_pkg.sv ***
// Register map, field positions, reset values and codes for the tributary defect action control.
// Assumes registers are reached over a 32-bit APB slave, one aligned word per register index.
package tdac_pkg;
  localparam int NUM_TRIB = 4;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_AIS_CTRL  = 6'h10;
  localparam logic [5:0] IDX_RDI_CTRL  = 6'h11;
  localparam logic [5:0] IDX_AUX_CTRL  = 6'h12;
  localparam logic [5:0] IDX_PDI_CTRL  = 6'h13;
  localparam logic [5:0] IDX_TRIB_CFG  = 6'h20;
  localparam logic [5:0] IDX_LOP_IRQ   = 6'h27;
  localparam logic [5:0] IDX_MODE_CTRL = 6'h30;

  localparam int AIS_LOP_BIT = 6;
  localparam int RDI_AIS_BIT = 5;
  localparam int RDI_LOP_BIT = 6;
  localparam int RDI_LOM_BIT = 7;
  localparam int AUX_TIU_BIT = 0;
  localparam int AUX_TIM_BIT = 1;
  localparam int AUX_LABEL_UNSTABLE_STATE_BIT = 2;
  localparam int AUX_LABEL_MISMATCH_STATE_BIT = 3;
  localparam int AUX_NO_PAYLOAD_STATE_BIT = 4;
  localparam int AUX_BLK_AIS_BIT = 5;
  localparam int AUX_BLK_LOP_BIT = 6;
  localparam int AUX_BLK_LOM_BIT = 7;
  localparam int PDI_LABEL_BIT = 3;
  localparam int PDI_NO_PAYLOAD_STATE_BIT = 4;
  localparam int PDI_AIS_BIT = 5;
  localparam int PDI_LOP_BIT = 6;
  localparam int CFG_FORCE_BIT = 0;
  localparam int CFG_IDLE_BIT = 1;
  localparam int CFG_INV_BIT = 2;
  localparam int CFG_IRQEN_BIT = 3;
  localparam int CFG_LOST_BIT = 4;
  localparam int CFG_FOLLOW_BIT = 5;
  localparam int CFG_LAYOUT_LSB = 6;
  localparam int MODE_TU3_BIT = 0;
  localparam int MODE_FILLER_BIT = 1;
  localparam int IRQ_FLAG_BIT = 0;

  localparam logic [7:0] RST_AIS_CTRL  = 8'h00;
  localparam logic [7:0] RST_RDI_CTRL  = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL  = 8'hE0;
  localparam logic [7:0] RST_PDI_CTRL  = 8'h00;
  localparam logic [7:0] RST_TRIB_CFG  = 8'hC0;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] MASK_AIS_CTRL  = 8'h40;
  localparam logic [7:0] MASK_RDI_CTRL  = 8'hE0;
  localparam logic [7:0] MASK_PDI_CTRL  = 8'h78;
  localparam logic [7:0] MASK_TRIB_CFG  = 8'hEF;
  localparam logic [7:0] MASK_MODE_CTRL = 8'h03;

  localparam logic [2:0] LABEL_PDI_CODE  = 3'h6;
  localparam logic [2:0] LABEL_NO_PAYLOAD_STATE_CODE = 3'h0;
  localparam logic [7:0] BYTE_ONES  = 8'hFF;
  localparam logic [7:0] BYTE_ZEROS = 8'h00;
  localparam logic [3:0] DEPTH_LOW  = 4'h2;
  localparam logic [3:0] DEPTH_HIGH = 4'hD;

  // Active tributaries of the group for a layout code; TU3 keeps only the first
  function automatic logic [3:0] active_mask(input logic [1:0] layout, input logic tu3);
    logic [3:0] m;
    m = 4'h0;
    if (tu3)
      m = 4'h1;
    else
      case (layout)
        2'h0: m = 4'h1;
        2'h1: m = 4'h3;
        2'h2: m = 4'h7;
        default: m = 4'hF;
      endcase
    return m;
  endfunction
endpackage

// *** rtl/tdac_defect_eval.sv ***
// Defect cause combiner for one tributary: remote, auxiliary remote and path defect terms.
// Assumes alarm states arrive from monitors on the same clock; output is combinational.
`timescale 1ns/1ps
module tdac_defect_eval (
  input  wire logic       aisState,
  input  wire logic       lossState,
  input  wire logic       lomState,
  input  wire logic       tiuState,
  input  wire logic       timState,
  input  wire logic       psluState,
  input  wire logic       pslmState,
  input  wire logic       uneqState,
  input  wire logic [2:0] labelCode,
  input  wire logic [7:0] rdiCtrl,
  input  wire logic [7:0] auxCtrl,
  input  wire logic [7:0] pdiCtrl,
  output logic            rdiTerm,
  output logic            auxTerm,
  output logic            pdiTerm
);
  logic auxRaw;
  logic auxBlock;

  always_comb
  begin
    rdiTerm = (aisState & rdiCtrl[tdac_pkg::RDI_AIS_BIT])
            | (lossState & rdiCtrl[tdac_pkg::RDI_LOP_BIT])
            | (lomState & rdiCtrl[tdac_pkg::RDI_LOM_BIT]);
    auxRaw = (tiuState & auxCtrl[tdac_pkg::AUX_TIU_BIT])
           | (timState & auxCtrl[tdac_pkg::AUX_TIM_BIT])
           | (psluState & auxCtrl[tdac_pkg::AUX_LABEL_UNSTABLE_STATE_BIT])
           | (pslmState & auxCtrl[tdac_pkg::AUX_LABEL_MISMATCH_STATE_BIT])
           | (uneqState & auxCtrl[tdac_pkg::AUX_NO_PAYLOAD_STATE_BIT]);
    auxBlock = (lossState & auxCtrl[tdac_pkg::AUX_BLK_LOP_BIT])
             | (aisState & auxCtrl[tdac_pkg::AUX_BLK_AIS_BIT])
             | (lomState & auxCtrl[tdac_pkg::AUX_BLK_LOM_BIT]);
    auxTerm = auxRaw & ~auxBlock;
    pdiTerm = ((labelCode == tdac_pkg::LABEL_PDI_CODE) & pdiCtrl[tdac_pkg::PDI_LABEL_BIT])
            | ((labelCode == tdac_pkg::LABEL_NO_PAYLOAD_STATE_CODE) & pdiCtrl[tdac_pkg::PDI_NO_PAYLOAD_STATE_BIT])
            | (aisState & pdiCtrl[tdac_pkg::PDI_AIS_BIT])
            | (lossState & pdiCtrl[tdac_pkg::PDI_LOP_BIT]);
  end
endmodule

// *** rtl/tdac_stream_insert.sv ***
// Outgoing byte and pointer-flag override for the first tributary: AIS, idle and flag inversion.
// Assumes the framer marks the V5 (or C2) byte and hands the pointer flag nibble alongside.
`timescale 1ns/1ps
module tdac_stream_insert (
  input  wire logic [7:0] inByte,
  input  wire logic       inIsV5,
  input  wire logic [3:0] inNdf,
  input  wire logic       forceAis,
  input  wire logic       lossAis,
  input  wire logic       insertIdle,
  input  wire logic       flagInvert,
  input  wire logic       fillerOnes,
  input  wire logic       tu3Mode,
  output logic [7:0]      outByte,
  output logic [3:0]      outNdf
);
  logic aisOn;
  logic [7:0] filler;

  always_comb
  begin
    // Idle wins over AIS; pointer still passes through computed as usual
    aisOn = (forceAis | lossAis) & ~insertIdle;
    // A TU3 needs zero filler so its label reads unequipped
    filler = (fillerOnes & ~tu3Mode) ? tdac_pkg::BYTE_ONES : tdac_pkg::BYTE_ZEROS;
    outByte = inByte;
    if (insertIdle)
      outByte = inIsV5 ? tdac_pkg::BYTE_ZEROS : filler;
    else if (aisOn)
      outByte = tdac_pkg::BYTE_ONES;
    outNdf = inNdf;
    if (aisOn)
      outNdf = 4'hF;
    else if (flagInvert)
      outNdf = ~inNdf;
  end
endmodule

// *** rtl/tdac_top.sv ***
// Tributary defect action control: APB registers, per-tributary defect reporting,
// first-tributary stream overrides, loss-of-pointer flag and pointer follower requests.
// Assumes alarm states, stream and pointer events come from logic on sys_clk.
`timescale 1ns/1ps
module tdac_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  aisState,
  input  wire logic [3:0]  lossState,
  input  wire logic [3:0]  lomState,
  input  wire logic [3:0]  tiuState,
  input  wire logic [3:0]  timState,
  input  wire logic [3:0]  psluState,
  input  wire logic [3:0]  pslmState,
  input  wire logic [3:0]  uneqState,
  input  wire logic [11:0] labelCode,
  output logic [3:0]       rdiOut,
  output logic [3:0]       auxRdiOut,
  output logic [3:0]       pathDefectOut,
  input  wire logic [7:0]  inByte,
  input  wire logic        inValid,
  input  wire logic        inIsV5,
  input  wire logic [3:0]  inNdf,
  input  wire logic        mfBoundary,
  output logic [7:0]       outByte,
  output logic             outValid,
  output logic [3:0]       outNdf,
  input  wire logic        tuJust,
  input  wire logic        auJust,
  input  wire logic [3:0]  bufDepth,
  output logic             justReq,
  output logic             followerMode,
  output logic             alarmIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] aisCtrl_q;
  logic [7:0] rdiCtrl_q;
  logic [7:0] auxCtrl_q;
  logic [7:0] pdiCtrl_q;
  logic [7:0] cfg_q;
  logic [7:0] mode_q;
  logic       lopFlag_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] readValue;
  logic       regHit;
  logic       accessGo;
  logic       xferDone;
  logic       wrDone;
  logic       rdDone;
  logic [5:0] regIdx;
  logic [7:0] wrByte;

  assign regIdx   = paddr[7:2];
  assign wrByte   = pwdata[7:0];
  assign accessGo = psel & penable & ~pready_q;
  assign xferDone = psel & penable & pready_q;
  assign wrDone   = xferDone & pwrite & regHit;
  assign rdDone   = xferDone & ~pwrite & regHit;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, registered answer
  always_comb
  begin
    regHit = 1'b1;
    readValue = 8'h00;
    case (regIdx)
      tdac_pkg::IDX_AIS_CTRL:  readValue = aisCtrl_q;
      tdac_pkg::IDX_RDI_CTRL:  readValue = rdiCtrl_q;
      tdac_pkg::IDX_AUX_CTRL:  readValue = auxCtrl_q;
      tdac_pkg::IDX_PDI_CTRL:  readValue = pdiCtrl_q;
      tdac_pkg::IDX_TRIB_CFG:
      begin
        readValue = cfg_q;
        readValue[tdac_pkg::CFG_LOST_BIT] = lossState[0];
      end
      tdac_pkg::IDX_LOP_IRQ:   readValue[tdac_pkg::IRQ_FLAG_BIT] = lopFlag_q;
      tdac_pkg::IDX_MODE_CTRL: readValue = mode_q;
      default:                 regHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= accessGo;
      pslverr_q <= accessGo & ~regHit;
      if (accessGo)
        prdata_q <= {24'h000000, readValue};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      aisCtrl_q <= tdac_pkg::RST_AIS_CTRL;
      rdiCtrl_q <= tdac_pkg::RST_RDI_CTRL;
      auxCtrl_q <= tdac_pkg::RST_AUX_CTRL;
      pdiCtrl_q <= tdac_pkg::RST_PDI_CTRL;
      cfg_q     <= tdac_pkg::RST_TRIB_CFG;
      mode_q    <= tdac_pkg::RST_MODE_CTRL;
    end
    else if (wrDone)
    begin
      case (regIdx)
        tdac_pkg::IDX_AIS_CTRL:  aisCtrl_q <= wrByte & tdac_pkg::MASK_AIS_CTRL;
        tdac_pkg::IDX_RDI_CTRL:  rdiCtrl_q <= wrByte & tdac_pkg::MASK_RDI_CTRL;
        tdac_pkg::IDX_AUX_CTRL:  auxCtrl_q <= wrByte;
        tdac_pkg::IDX_PDI_CTRL:  pdiCtrl_q <= wrByte & tdac_pkg::MASK_PDI_CTRL;
        tdac_pkg::IDX_TRIB_CFG:  cfg_q     <= wrByte & tdac_pkg::MASK_TRIB_CFG;
        tdac_pkg::IDX_MODE_CTRL: mode_q    <= wrByte & tdac_pkg::MASK_MODE_CTRL;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer alarm flag and interrupt
  logic lossPrev_q;
  logic aisPrev_q;
  logic lossEdge;
  logic aisEdge;

  assign lossEdge = lossState[0] ^ lossPrev_q;
  assign aisEdge  = aisState[0] ^ aisPrev_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      lossPrev_q <= 1'b0;
      aisPrev_q  <= 1'b0;
    end
    else
    begin
      lossPrev_q <= lossState[0];
      aisPrev_q  <= aisState[0];
    end
  end

  // A new edge in the read cycle keeps the flag; an edge one cycle earlier is cleared by the read without being returned
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      lopFlag_q <= 1'b0;
    else if (lossEdge)
      lopFlag_q <= 1'b1;
    else if (rdDone && regIdx == tdac_pkg::IDX_LOP_IRQ)
      lopFlag_q <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      alarmIrq <= 1'b0;
    else
      alarmIrq <= cfg_q[tdac_pkg::CFG_IRQEN_BIT] & (lossEdge | aisEdge);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Defect reporting per tributary
  logic [3:0] activeMask;
  logic [3:0] rdiTerm;
  logic [3:0] auxTerm;
  logic [3:0] pdiTerm;

  assign activeMask = tdac_pkg::active_mask(cfg_q[tdac_pkg::CFG_LAYOUT_LSB +: 2],
                                            mode_q[tdac_pkg::MODE_TU3_BIT]);

  for (genvar t = 0; t < tdac_pkg::NUM_TRIB; t++)
  begin : g_trib
    tdac_defect_eval u_eval (
      .aisState  (aisState[t]),
      .lossState (lossState[t]),
      .lomState  (lomState[t]),
      .tiuState  (tiuState[t]),
      .timState  (timState[t]),
      .psluState (psluState[t]),
      .pslmState (pslmState[t]),
      .uneqState (uneqState[t]),
      .labelCode (labelCode[3*t +: 3]),
      .rdiCtrl   (rdiCtrl_q),
      .auxCtrl   (auxCtrl_q),
      .pdiCtrl   (pdiCtrl_q),
      .rdiTerm   (rdiTerm[t]),
      .auxTerm   (auxTerm[t]),
      .pdiTerm   (pdiTerm[t])
    );
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rdiOut        <= 4'h0;
      auxRdiOut     <= 4'h0;
      pathDefectOut <= 4'h0;
    end
    else
    begin
      rdiOut        <= rdiTerm & activeMask;
      auxRdiOut     <= auxTerm & activeMask;
      pathDefectOut <= pdiTerm & activeMask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing stream of the first tributary
  logic       lossAis_q;
  logic [7:0] insByte;
  logic [3:0] insNdf;

  // AIS may start at once but only lifts on a multiframe boundary
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      lossAis_q <= 1'b0;
    else if (lossState[0] && aisCtrl_q[tdac_pkg::AIS_LOP_BIT])
      lossAis_q <= 1'b1;
    else if (mfBoundary)
      lossAis_q <= 1'b0;
  end

  tdac_stream_insert u_insert (
    .inByte     (inByte),
    .inIsV5     (inIsV5),
    .inNdf      (inNdf),
    .forceAis   (cfg_q[tdac_pkg::CFG_FORCE_BIT]),
    .lossAis    (lossAis_q),
    .insertIdle (cfg_q[tdac_pkg::CFG_IDLE_BIT]),
    .flagInvert (cfg_q[tdac_pkg::CFG_INV_BIT]),
    .fillerOnes (mode_q[tdac_pkg::MODE_FILLER_BIT]),
    .tu3Mode    (mode_q[tdac_pkg::MODE_TU3_BIT]),
    .outByte    (insByte),
    .outNdf     (insNdf)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      outByte  <= 8'h00;
      outNdf   <= 4'h0;
      outValid <= 1'b0;
    end
    else
    begin
      outValid <= inValid;
      if (inValid)
      begin
        outByte <= insByte;
        outNdf  <= insNdf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer justification requests
  logic [3:0] depthPrev_q;
  logic       followOn;

  assign followOn = cfg_q[tdac_pkg::CFG_FOLLOW_BIT];

  // Outside follower mode only a depth beyond the dead zone justifies
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      depthPrev_q  <= 4'h0;
      justReq      <= 1'b0;
      followerMode <= 1'b0;
    end
    else
    begin
      depthPrev_q  <= bufDepth;
      followerMode <= followOn;
      if (followOn)
        justReq <= (bufDepth != depthPrev_q) | tuJust | auJust;
      else
        justReq <= (bufDepth < tdac_pkg::DEPTH_LOW) | (bufDepth > tdac_pkg::DEPTH_HIGH);
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_rdi_from_ais: assert property (@(posedge sys_clk) disable iff (!rst_b)
    aisState[0] && rdiCtrl_q[tdac_pkg::RDI_AIS_BIT] |=> rdiOut[0])
    else $error("AIS did not raise RDI");
  a_rdi_from_loss: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lossState[0] && rdiCtrl_q[tdac_pkg::RDI_LOP_BIT] |=> rdiOut[0])
    else $error("Pointer loss did not raise RDI");
  a_rdi_from_lom: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lomState[0] && rdiCtrl_q[tdac_pkg::RDI_LOM_BIT] |=> rdiOut[0])
    else $error("Multiframe loss did not raise RDI");
  a_aux_loss_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lossState[0] && auxCtrl_q[tdac_pkg::AUX_BLK_LOP_BIT] |=> !auxRdiOut[0])
    else $error("Auxiliary RDI shown during blocked pointer loss");
  a_aux_ais_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
    aisState[0] && auxCtrl_q[tdac_pkg::AUX_BLK_AIS_BIT] |=> !auxRdiOut[0])
    else $error("Auxiliary RDI shown during blocked AIS");
  a_pdi_label_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
    labelCode[2:0] == tdac_pkg::LABEL_PDI_CODE && pdiCtrl_q[tdac_pkg::PDI_LABEL_BIT] |=> pathDefectOut[0])
    else $error("Label defect code did not raise PDI");
  a_idle_v5_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inValid && inIsV5 && cfg_q[tdac_pkg::CFG_IDLE_BIT] |=> outValid && outByte == 8'h00)
    else $error("V5 not zeroed under idle");
  a_force_all_ones: assert property (@(posedge sys_clk) disable iff (!rst_b)
    inValid && cfg_q[tdac_pkg::CFG_FORCE_BIT] && !cfg_q[tdac_pkg::CFG_IDLE_BIT]
    |=> outByte == 8'hFF && outNdf == 4'hF)
    else $error("Forced AIS not all ones");
  a_loss_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $changed(lossState[0]) && lossPrev_q != lossState[0] |=> lopFlag_q)
    else $error("Loss flag missed an edge");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg_q[tdac_pkg::CFG_IRQEN_BIT] |=> !alarmIrq)
    else $error("Interrupt raised while masked");
  a_tu3_one_trib: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode_q[tdac_pkg::MODE_TU3_BIT] ##1 mode_q[tdac_pkg::MODE_TU3_BIT] |-> rdiOut[3:1] == 3'h0)
    else $error("TU3 mode reported beyond first tributary");
endmodule

// *** testbench/tdac_far_model.sv ***
// Far-side framer model: first-tributary bytes, V5 marks, pointer flag nibble, multiframe marks.
// Assumes runEn from the bench; all outputs move on the rising edge of sys_clk.
`timescale 1ns/1ps
module tdac_far_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       runEn,
  output logic [7:0]      inByte,
  output logic            inValid,
  output logic            inIsV5,
  output logic [3:0]      inNdf,
  output logic            mfBoundary
);
  logic [7:0] cnt_q;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cnt_q <= 8'h00;
    else if (runEn)
      cnt_q <= cnt_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////
  // Released lane toggles, so a stale byte never passes for data
  always_ff @(posedge sys_clk)
  begin
    inValid    <= rst_b && runEn;
    inByte     <= !rst_b ? 8'h00 : runEn ? cnt_q ^ 8'h5A : ~inByte;
    inIsV5     <= rst_b && runEn && cnt_q[2:0] == 3'h0;
    inNdf      <= cnt_q[3] ? 4'h6 : 4'h9;
    mfBoundary <= rst_b && runEn && cnt_q[4:0] == 5'h1F;
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the tributary defect action control.
// Assumes the far-side stream model and APB at 200 MHz.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, rst_b, psel, penable, pwrite, runEn, tuJust, auJust, errSeen;
  logic        pready, pslverr, inValid, inIsV5, mfBoundary, outValid, justReq, followerMode, alarmIrq;
  logic [7:0]  paddr, inByte, outByte;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  st [8];
  logic [3:0]  rdiOut, auxRdiOut, pathDefectOut, inNdf, outNdf, bufDepth;
  logic [11:0] labelCode;
  int          failures, totalChecks, nIrq, nJust;
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  tdac_top tdac_top_i (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .aisState(st[0]), .lossState(st[1]), .lomState(st[2]), .tiuState(st[3]), .timState(st[4]),
    .psluState(st[5]), .pslmState(st[6]), .uneqState(st[7]), .labelCode, .rdiOut, .auxRdiOut,
    .pathDefectOut, .inByte, .inValid, .inIsV5, .inNdf, .mfBoundary, .outByte, .outValid, .outNdf,
    .tuJust, .auJust, .bufDepth, .justReq, .followerMode, .alarmIrq);
  tdac_far_model tdac_far_model_i (.sys_clk, .rst_b, .runEn, .inByte, .inValid, .inIsV5, .inNdf, .mfBoundary);
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] pick(input int o);
    return o == 0 ? rdiOut : o == 1 ? auxRdiOut : pathDefectOut;
  endfunction
  // Request held until pready is seen high at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, {24'h000000, d});
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    rc(8'h48, 32'hE0);
    rc(8'h80, 32'hC0);
    wr(8'h80, 8'h50);
    rc(8'h80, 32'h40);
    wr(8'h80, 8'hC0);
    wr(8'h4C, 8'hFF);
    rc(8'h4C, 32'h78);
    wr(8'h4C, 8'h00);
    rc(8'h04, 32'h0);
    chk(errSeen, 1'h1);
    $display("register map done");
  endtask
  // One cause, checked with its enable off and then on
  task alm(input logic [7:0] a, off, on, input int k, input logic [3:0] v, input logic [11:0] lab,
           input int o, input logic [3:0] eOff, eOn);
    @(posedge sys_clk);
    st[k] <= v;
    labelCode <= lab;
    wr(a, off);
    settle;
    chk(pick(o), eOff);
    wr(a, on);
    settle;
    chk(pick(o), eOn);
    @(posedge sys_clk);
    st[k] <= 4'h0;
    $display("alarm case done");
  endtask
  task t_layout;
    @(posedge sys_clk);
    st[0] <= 4'hF;
    wr(8'h44, 8'h20);
    for (int l = 0; l < 4; l++)
    begin
      wr(8'h80, {l[1:0], 6'h00});
      settle;
      chk(rdiOut, 4'hF >> (3 - l));
    end
    wr(8'hC0, 8'h01);
    settle;
    chk(rdiOut, 4'h1);
    wr(8'hC0, 8'h00);
    st[0] <= 4'h0;
    wr(8'h44, 8'h00);
    $display("layout done");
  endtask
  task t_strm(input logic [7:0] cfg, mv, input int m, input logic [7:0] fl, input logic iv);
    logic [7:0] b;
    logic       v;
    logic [3:0] n;
    wr(8'hC0, mv);
    wr(8'h80, cfg);
    repeat (3) @(posedge sys_clk);
    repeat (16)
    begin
      @(posedge sys_clk);
      b = inByte;
      v = inIsV5;
      n = inNdf;
      #1;
      chk(outValid, 1'h1);
      chk(outByte, m == 1 ? 8'hFF : m == 2 ? (v ? 8'h00 : fl) : b);
      chk(outNdf, m == 1 ? 4'hF : 4'(iv ? ~n : n));
    end
    $display("stream case done");
  endtask
  // Loss-driven AIS starts at once but lifts only at the next multiframe mark
  task t_lais;
    wr(8'h80, 8'hC0);
    wr(8'h40, 8'h40);
    st[1] <= 4'h1;
    settle;
    chk(outByte, 8'hFF);
    @(posedge sys_clk);
    st[1] <= 4'h0;
    do @(posedge sys_clk); while (mfBoundary !== 1'h1);
    #1;
    chk(outByte, 8'hFF);
    @(posedge sys_clk);
    #1;
    chk(outByte !== 8'hFF, 1'h1);
    wr(8'h40, 8'h00);
    $display("pointer loss AIS done");
  endtask
  // Drives one change, then counts interrupt and justification cycles
  task watch(input logic [3:0] ais, loss, dep, input logic [1:0] pl);
    nIrq = 0;
    nJust = 0;
    @(posedge sys_clk);
    st[0] <= ais;
    st[1] <= loss;
    bufDepth <= dep;
    {auJust, tuJust} <= pl;
    repeat (4)
    begin
      @(posedge sys_clk);
      {auJust, tuJust} <= 2'h0;
      #1;
      nIrq += alarmIrq === 1'h1;
      nJust += justReq === 1'h1;
    end
  endtask
  task t_irq;
    xfer(1'h0, 8'h9C, 32'h0);
    wr(8'h80, 8'hC8);
    watch(4'h0, 4'h1, 4'h7, 2'h0);
    chk(nIrq, 1);
    rc(8'h80, 32'hD8);
    rc(8'h9C, 32'h1);
    rc(8'h9C, 32'h0);
    wr(8'h80, 8'hC0);
    watch(4'h0, 4'h0, 4'h7, 2'h0);
    chk(nIrq, 0);
    rc(8'h9C, 32'h1);
    wr(8'h80, 8'hC8);
    watch(4'h1, 4'h0, 4'h7, 2'h0);
    chk(nIrq, 1);
    watch(4'h0, 4'h0, 4'h7, 2'h0);
    chk(nIrq, 1);
    wr(8'h80, 8'hC0);
    $display("interrupt done");
  endtask
  task t_pf;
    watch(4'h0, 4'h0, 4'h8, 2'h0);
    chk(nJust, 0);
    wr(8'h80, 8'hE0);
    settle;
    chk(followerMode, 1'h1);
    watch(4'h0, 4'h0, 4'h9, 2'h0);
    chk(nJust != 0, 1'h1);
    for (int p = 1; p < 3; p++)
    begin
      watch(4'h0, 4'h0, 4'h9, p[1:0]);
      chk(nJust != 0, 1'h1);
    end
    wr(8'h80, 8'hC0);
    $display("follower done");
  endtask
  ////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {psel, penable, pwrite, runEn, tuJust, auJust, rst_b} = 7'h00;
    {paddr, pwdata, labelCode, bufDepth} = {8'h00, 32'h0, 12'hFFF, 4'h7};
    for (int k = 0; k < 8; k++)
      st[k] = 4'h0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    runEn <= 1'h1;
    t_regs;
    alm(8'h44, 8'h00, 8'h20, 0, 4'hF, 12'hFFF, 0, 4'h0, 4'hF);
    alm(8'h44, 8'h00, 8'h40, 1, 4'hF, 12'hFFF, 0, 4'h0, 4'hF);
    alm(8'h44, 8'h00, 8'h80, 2, 4'hF, 12'hFFF, 0, 4'h0, 4'hF);
    for (int i = 0; i < 5; i++)
      alm(8'h48, 8'h00, 8'h01 << i, 3 + i, 4'hF, 12'hFFF, 1, 4'h0, 4'hF);
    @(posedge sys_clk);
    st[3] <= 4'hF;
    alm(8'h48, 8'h01, 8'h21, 0, 4'h5, 12'hFFF, 1, 4'hF, 4'hA);
    alm(8'h48, 8'h01, 8'h41, 1, 4'h5, 12'hFFF, 1, 4'hF, 4'hA);
    alm(8'h48, 8'h01, 8'h81, 2, 4'h5, 12'hFFF, 1, 4'hF, 4'hA);
    st[3] <= 4'h0;
    alm(8'h4C, 8'h00, 8'h08, 0, 4'h0, 12'hFBE, 2, 4'h0, 4'h5);
    alm(8'h4C, 8'h00, 8'h10, 0, 4'h0, 12'hFC7, 2, 4'h0, 4'h2);
    alm(8'h4C, 8'h00, 8'h20, 0, 4'h8, 12'hFFF, 2, 4'h0, 4'h8);
    alm(8'h4C, 8'h00, 8'h40, 1, 4'h3, 12'hFFF, 2, 4'h0, 4'h3);
    wr(8'h4C, 8'h00);
    t_layout;
    t_strm(8'hC0, 8'h00, 0, 8'h00, 1'h0);
    t_strm(8'hC1, 8'h00, 1, 8'h00, 1'h0);
    t_strm(8'hC3, 8'h00, 2, 8'h00, 1'h0);
    t_strm(8'hC2, 8'h02, 2, 8'hFF, 1'h0);
    t_strm(8'hC6, 8'h00, 2, 8'h00, 1'h1);
    t_strm(8'hC5, 8'h00, 1, 8'h00, 1'h0);
    t_strm(8'hC4, 8'h00, 0, 8'h00, 1'h1);
    t_strm(8'hC2, 8'h03, 2, 8'h00, 1'h0);
    wr(8'hC0, 8'h00);
    t_lais;
    t_irq;
    t_pf;
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test;
  end
endmodule
